// ==== common/smc_pkg.sv ====
`default_nettype none
package smc_pkg;

   // ****************************************
   // Sleep mode codes
   // ****************************************
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_NOISE = 3'h1;
   localparam logic [2:0] MODE_PDOWN = 3'h2;
   localparam logic [2:0] MODE_PSAVE = 3'h3;
   localparam logic [2:0] MODE_RSV4 = 3'h4;
   localparam logic [2:0] MODE_RSV5 = 3'h5;
   localparam logic [2:0] MODE_STBY = 3'h6;
   localparam logic [2:0] MODE_XSTBY = 3'h7;

   // ****************************************
   // Timing counts
   // ****************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int HALT_CYCLES = 4;
   localparam int STBY_WAKE_CYCLES = 6;
   localparam logic [7:0] HALT_CNT = 8'(HALT_CYCLES);
   localparam logic [7:0] STBY_CNT = 8'(STBY_WAKE_CYCLES);
   localparam int PRR_WIDTH = 8;
   localparam logic [7:0] PRR_RESET = 8'h00;

   // ****************************************
   // Gated peripheral positions in power reduction vector
   // ****************************************
   localparam int PR_ADC = 0;
   localparam int PR_SPI = 1;
   localparam int PR_TIM0 = 2;
   localparam int PR_TIM1 = 3;
   localparam int PR_TWI = 4;
   localparam int PR_USART = 5;
   localparam int PR_USB = 6;
   localparam int PR_TIM3 = 7;

   // Wake source bundle
   typedef struct packed {
      logic extLowIrq;     // any of the four low external lines
      logic extLevelIrq;   // sixth line, level sensitive
      logic extEdgeIrq;    // sixth line, edge event
      logic pinChangeIrq;
      logic twiAddrMatch;
      logic twiIrq;
      logic storeReadyIrq;
      logic convDoneIrq;
      logic wdtIrq;
      logic busPowerIrq;
      logic busWakeIrq;
      logic usbSyncIrq;
      logic otherIoIrq;
   } smc_wake_t;

   // Clock domain enables
   typedef struct packed {
      logic cpuClk;
      logic flashClk;
      logic ioClk;
      logic convClk;
      logic usbClk;
      logic mainOsc;
   } smc_clk_en_t;

endpackage
`default_nettype wire

// ==== core/smc_wake_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module smc_wake_decode (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [2:0] mode,
   input wire smc_pkg::smc_wake_t src,
   output logic wake_q
);

   // ****************************************
   // Per-mode wake filter, registered
   // ****************************************
   logic wakeD;

   // Table of allowed sources per mode
   always_comb
   begin
      wakeD = 1'b0;
      case (mode)
         smc_pkg::MODE_IDLE:
            wakeD = |src;
         smc_pkg::MODE_NOISE:
            wakeD = src.convDoneIrq | src.wdtIrq | src.twiIrq | src.twiAddrMatch
                  | src.storeReadyIrq | src.extLevelIrq | src.extLowIrq
                  | src.pinChangeIrq | src.usbSyncIrq
                  | src.busPowerIrq | src.busWakeIrq;
         smc_pkg::MODE_PDOWN, smc_pkg::MODE_PSAVE,
         smc_pkg::MODE_STBY, smc_pkg::MODE_XSTBY:
            wakeD = src.twiAddrMatch | src.extLevelIrq | src.extLowIrq
                  | src.pinChangeIrq | src.wdtIrq
                  | src.busPowerIrq | src.busWakeIrq;
         default:
            wakeD = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         wake_q <= 1'b0;
      else
         wake_q <= wakeD;
   end

endmodule
`default_nettype wire

// ==== core/smc_sleep_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl (
   input wire logic mclk,
   input wire logic reset,
   input wire logic sleepEnable,
   input wire logic [2:0] sleepModeSelect,
   input wire logic sleepInstr,
   input wire logic extCrystal,
   input wire logic [15:0] resetTimeoutCycles,
   input wire logic convEnabled,
   input wire logic wakeReset,
   input wire smc_pkg::smc_wake_t wakeSrc,
   input wire logic [7:0] powerReduction,
   output smc_pkg::smc_clk_en_t clkEn_q,
   output logic [7:0] periphClkEn_q,
   output logic [7:0] periphRegAccess_q,
   output logic coreHalt_q,
   output logic convStart_q,
   output logic irqAck_q,
   output logic resetVector_q,
   output logic asleep_q,
   output logic [2:0] activeMode_q
);

   // ****************************************
   // State machine
   // ****************************************
   typedef enum logic [3:0] {
      SMC_ACTIVE = 4'h1,
      SMC_SLEEP = 4'h2,
      SMC_START = 4'h4,
      SMC_HALT = 4'h8
   } smc_state_t;

   smc_state_t state_q, state_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] mode_q;
   logic wakeSeen;
   logic enterSleep;
   logic fromReset_q;
   logic [2:0] modeNow;

   // Decide whether a mode uses the power-down style wake delay
   function automatic logic isDeep(input logic [2:0] m);
      isDeep = (m == smc_pkg::MODE_PDOWN) || (m == smc_pkg::MODE_PSAVE);
   endfunction

   // Standby needs a crystal; without it we fall back to power-down
   function automatic logic isStandby(input logic [2:0] m, input logic xtal);
      isStandby = xtal && ((m == smc_pkg::MODE_STBY) || (m == smc_pkg::MODE_XSTBY));
   endfunction

   // Reserved codes act as no-ops
   function automatic logic isValid(input logic [2:0] m);
      isValid = (m != smc_pkg::MODE_RSV4) && (m != smc_pkg::MODE_RSV5);
   endfunction

   // Filtered wake indication for the latched mode
   smc_wake_decode uWake (
      .mclk(mclk),
      .reset(reset),
      .mode(modeNow),
      .src(wakeSrc),
      .wake_q(wakeSeen)
   );

   // Mode in force: the request while awake, the latched code once asleep
   // A stale code here could let a source of the old mode wake a deeper one
   assign modeNow = (state_q == SMC_ACTIVE) ? sleepModeSelect : mode_q;

   // Sleep only on enabled, valid request
   assign enterSleep = sleepInstr && sleepEnable && isValid(sleepModeSelect);

   // ****************************************
   // Next state and wait counter
   // ****************************************
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         SMC_ACTIVE:
         begin
            if (enterSleep)
               state_d = SMC_SLEEP;
         end
         SMC_SLEEP:
         begin
            if (wakeSeen)
            begin
               state_d = SMC_START;
               if (isStandby(mode_q, extCrystal))
                  cnt_d = 16'(smc_pkg::STBY_CNT);
               else if (mode_q == smc_pkg::MODE_IDLE || mode_q == smc_pkg::MODE_NOISE)
                  cnt_d = 16'h0001;
               else
                  cnt_d = (resetTimeoutCycles == 16'h0000) ? 16'h0001
                        : resetTimeoutCycles;
            end
         end
         SMC_START:
         begin
            if (cnt_q <= 16'h0001)
            begin
               state_d = SMC_HALT;
               cnt_d = 16'(smc_pkg::HALT_CNT);
            end
            else
               cnt_d = cnt_q - 16'h0001;
         end
         SMC_HALT:
         begin
            if (cnt_q <= 16'h0001)
               state_d = SMC_ACTIVE;
            else
               cnt_d = cnt_q - 16'h0001;
         end
         default:
            state_d = SMC_ACTIVE;
      endcase
      if (wakeReset)
         state_d = SMC_ACTIVE;
   end

   // State register
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= SMC_ACTIVE;
         cnt_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Mode latched at sleep entry so later writes cannot change a running sleep
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         mode_q <= smc_pkg::MODE_IDLE;
      else if (state_q == SMC_ACTIVE && enterSleep)
         mode_q <= sleepModeSelect;
   end

   // ****************************************
   // Clock domain enables
   // ****************************************
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         clkEn_q <= '1;
      else if (state_d != SMC_SLEEP)
         clkEn_q <= '1;
      else
      begin
         clkEn_q.cpuClk <= 1'b0;
         clkEn_q.flashClk <= 1'b0;
         case (state_q == SMC_ACTIVE ? sleepModeSelect : mode_q)
            smc_pkg::MODE_IDLE:
            begin
               clkEn_q.ioClk <= 1'b1;
               clkEn_q.convClk <= 1'b1;
               clkEn_q.usbClk <= 1'b1;
               clkEn_q.mainOsc <= 1'b1;
            end
            smc_pkg::MODE_NOISE:
            begin
               clkEn_q.ioClk <= 1'b0;
               clkEn_q.convClk <= 1'b1;
               clkEn_q.usbClk <= 1'b1;
               clkEn_q.mainOsc <= 1'b1;
            end
            smc_pkg::MODE_STBY, smc_pkg::MODE_XSTBY:
            begin
               clkEn_q.ioClk <= 1'b0;
               clkEn_q.convClk <= 1'b0;
               clkEn_q.usbClk <= 1'b0;
               clkEn_q.mainOsc <= extCrystal;
            end
            default:
            begin
               clkEn_q.ioClk <= 1'b0;
               clkEn_q.convClk <= 1'b0;
               clkEn_q.usbClk <= 1'b0;
               clkEn_q.mainOsc <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Per-peripheral gating
   // ****************************************
   // Gating follows the I/O clock; deeper modes already stop the I/O clock
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         periphClkEn_q <= '1;
         periphRegAccess_q <= '1;
      end
      else
      begin
         periphClkEn_q <= ~powerReduction
                          & {8{state_d != SMC_SLEEP || modeNow == smc_pkg::MODE_IDLE}};
         periphRegAccess_q <= ~powerReduction;
      end
   end

   // ****************************************
   // Core side outputs
   // ****************************************
   // Core held while asleep, during start-up and the halt cycles
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         coreHalt_q <= 1'b0;
         asleep_q <= 1'b0;
         activeMode_q <= smc_pkg::MODE_IDLE;
      end
      else
      begin
         coreHalt_q <= (state_d != SMC_ACTIVE);
         asleep_q <= (state_d == SMC_SLEEP);
         activeMode_q <= (state_q == SMC_ACTIVE) ? sleepModeSelect : mode_q;
      end
   end

   // One-cycle conversion start on entry to Idle or noise reduction
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         convStart_q <= 1'b0;
      else
         convStart_q <= state_q == SMC_ACTIVE && enterSleep && convEnabled
                        && (sleepModeSelect == smc_pkg::MODE_IDLE
                        || sleepModeSelect == smc_pkg::MODE_NOISE);
   end

   // Handler request at release, or reset vector when woken by reset
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         fromReset_q <= 1'b0;
         irqAck_q <= 1'b0;
         resetVector_q <= 1'b0;
      end
      else
      begin
         fromReset_q <= wakeReset && state_q != SMC_ACTIVE;
         irqAck_q <= state_q == SMC_HALT && state_d == SMC_ACTIVE && !wakeReset;
         resetVector_q <= wakeReset && state_q != SMC_ACTIVE && !fromReset_q;
      end
   end

endmodule
`default_nettype wire

// ==== tb/smc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Core and irq model
// ****************
module smc_core_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic sleepReq,
   input wire logic irqReq,
   input wire logic irqAck_q,
   input wire smc_pkg::smc_wake_t spurSrc,
   output logic sleepInstr,
   output smc_pkg::smc_wake_t wakeSrc
);
   logic levelIrq_q;
   // Sleep instruction only on request
   always_ff @(posedge mclk or posedge reset)
      if (reset)
         sleepInstr <= 1'b0;
      else
         sleepInstr <= sleepReq;
   // Level held until handler runs, so even a one-cycle request is kept
   always_ff @(posedge mclk or posedge reset)
      if (reset)
         levelIrq_q <= 1'b0;
      else if (irqReq)
         levelIrq_q <= 1'b1;
      else if (irqAck_q)
         levelIrq_q <= 1'b0;
   // Low external line on top of stray sources
   assign wakeSrc = spurSrc | {levelIrq_q, 12'h000};
endmodule
`default_nettype wire

// ==== tb/smc_sleep_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Sleep checks
// ****************
module smc_sleep_ctrl_asserts (
   input wire logic mclk,
   input wire logic reset,
   input wire logic sleepEnable,
   input wire logic [2:0] sleepModeSelect,
   input wire logic sleepInstr,
   input wire logic extCrystal,
   input wire logic convEnabled,
   input wire logic wakeReset,
   input wire smc_pkg::smc_wake_t wakeSrc,
   input wire logic [7:0] powerReduction,
   input wire smc_pkg::smc_clk_en_t clkEn_q,
   input wire logic [7:0] periphRegAccess_q,
   input wire logic coreHalt_q,
   input wire logic convStart_q,
   input wire logic resetVector_q,
   input wire logic asleep_q,
   input wire logic [2:0] activeMode_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Request taken while fully awake
   sequence s_req;
      sleepInstr && sleepEnable && !asleep_q && !coreHalt_q;
   endsequence
   // Interrupt wake, reset wake excluded
   sequence s_wake;
      $fell(asleep_q) && !resetVector_q && !$past(wakeReset);
   endsequence
   property p_seOff;
      sleepInstr && !sleepEnable && !asleep_q |=> !asleep_q;
   endproperty
   property p_rsvNop;
      s_req and (sleepModeSelect[2:1] == 2'h2) |=> (!asleep_q && clkEn_q == 6'h3F)[*2];
   endproperty
   property p_idleClk;
      asleep_q && activeMode_q == smc_pkg::MODE_IDLE |-> clkEn_q == 6'h0F;
   endproperty
   property p_deepClk;
      asleep_q && activeMode_q[2:1] == 2'h1 |-> clkEn_q == 6'h00;
   endproperty
   property p_stbyClk;
      asleep_q && extCrystal && activeMode_q[2:1] == 2'h3 |-> clkEn_q == 6'h01;
   endproperty
   property p_convStart;
      s_req and (convEnabled && sleepModeSelect[2:1] == 2'h0) |-> ##[0:2] convStart_q;
   endproperty
   property p_halt;
      s_wake |-> coreHalt_q[*4];
   endproperty
   property p_stbyWake;
      s_wake and (extCrystal && activeMode_q[2:1] == 2'h3) |-> ##[9:11] $fell(coreHalt_q);
   endproperty
   property p_idleWake;
      asleep_q && activeMode_q == smc_pkg::MODE_IDLE && wakeSrc.otherIoIrq |-> ##[1:4] !asleep_q;
   endproperty
   property p_rstWake;
      asleep_q && wakeReset |-> ##[1:2] (resetVector_q && !asleep_q);
   endproperty
   property p_access;
      1'b1 |=> periphRegAccess_q == ~$past(powerReduction);
   endproperty
   a_seOff: assert property (p_seOff) else $error("sleep entered with enable low");
   a_rsvNop: assert property (p_rsvNop) else $error("reserved code slept");
   a_idleClk: assert property (p_idleClk) else $error("idle clocks wrong");
   a_deepClk: assert property (p_deepClk) else $error("power-down clocks wrong");
   a_stbyClk: assert property (p_stbyClk) else $error("standby clocks wrong");
   a_convStart: assert property (p_convStart) else $error("no conversion start");
   a_halt: assert property (p_halt) else $error("halt too short");
   a_stbyWake: assert property (p_stbyWake) else $error("standby wake time wrong");
   a_idleWake: assert property (p_idleWake) else $error("idle not woken");
   a_rstWake: assert property (p_rstWake) else $error("reset wake wrong");
   a_access: assert property (p_access) else $error("register access wrong");
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_asserts smc_sleep_ctrl_asserts_inst (.mclk, .reset, .sleepEnable,
   .sleepModeSelect, .sleepInstr, .extCrystal, .convEnabled, .wakeReset, .wakeSrc, .powerReduction,
   .clkEn_q, .periphRegAccess_q, .coreHalt_q, .convStart_q, .resetVector_q, .asleep_q, .activeMode_q);
`default_nettype wire

// ==== tb/smc_sleep_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Sleep bench
// ****************
module smc_sleep_ctrl_tb;
   logic mclk, reset, sleepEnable, convEnabled, wakeReset, sleepReq, irqReq, sleepInstr, extCrystal;
   logic coreHalt_q, convStart_q, irqAck_q, resetVector_q, asleep_q, convSeen, rvSeen, ackSeen;
   logic [2:0] sleepModeSelect, activeMode_q;
   logic [7:0] powerReduction, periphClkEn_q, periphRegAccess_q;
   smc_pkg::smc_wake_t spurSrc, wakeSrc;
   smc_pkg::smc_clk_en_t clkEn_q;
   int n_errors, tests_run, cyc, k, cnt;
   logic [2:0] modes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h6};
   logic [5:0] clkExp [7] = '{6'h0F, 6'h07, 6'h00, 6'h00, 6'h01, 6'h01, 6'h00};
   int dly [7] = '{1, 1, 20, 20, 6, 6, 20};
   smc_sleep_ctrl smc_sleep_ctrl_inst (.mclk, .reset, .sleepEnable, .sleepModeSelect, .sleepInstr,
      .extCrystal, .resetTimeoutCycles(16'h0014), .convEnabled, .wakeReset, .wakeSrc,
      .powerReduction, .clkEn_q, .periphClkEn_q, .periphRegAccess_q, .coreHalt_q, .convStart_q,
      .irqAck_q, .resetVector_q, .asleep_q, .activeMode_q);
   smc_core_model smc_core_model_inst (.mclk, .reset, .sleepReq, .irqReq, .irqAck_q, .spurSrc,
      .sleepInstr, .wakeSrc);
   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Pulse catchers and hang limit, pulses last one cycle
   always @(posedge mclk)
   begin
      cyc++;
      if (convStart_q === 1'b1) convSeen = 1'b1;
      if (resetVector_q === 1'b1) rvSeen = 1'b1;
      if (irqAck_q === 1'b1) ackSeen = 1'b1;
      if (cyc == 4000)
      begin
         n_errors++;
         end_sim();
      end
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // One sleep instruction, then settle
   task automatic sleepCmd(logic [2:0] m, logic se);
      sleepModeSelect = m;
      sleepEnable = se;
      sleepReq = 1'b1;
      step(1);
      sleepReq = 1'b0;
      step(4);
   endtask
   task end_sim;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      {sleepEnable, wakeReset, sleepReq, irqReq, sleepModeSelect, powerReduction, spurSrc} = '0;
      convEnabled = 1'b1;
      extCrystal = 1'b1;
      reset = 1'b1;
      repeat (5) @(posedge mclk);
      #1 reset = 1'b0;
      step(1);
      sleepCmd(smc_pkg::MODE_IDLE, 1'b0);
      chk("asleepSeOff", asleep_q, 0);
      for (k = 4; k < 6; k++)
      begin
         sleepCmd(3'(k), 1'b1);
         chk("asleepRsv", asleep_q, 0);
         chk("clkRsv", clkEn_q, 6'h3F);
      end
      // Gating in active mode, module assumed idle first
      powerReduction = 8'h5A;
      step(2);
      chk("regAccess", periphRegAccess_q, 8'hA5);
      chk("periphClk", periphClkEn_q, 8'hA5);
      powerReduction = 8'h00;
      step(2);
      chk("periphClkOn", periphClkEn_q, 8'hFF);
      // Every mode: clocks, stray sources, wake timing except Idle; last pass is standby code without crystal
      for (k = 0; k < 7; k++)
      begin
         convSeen = 1'b0;
         extCrystal = (k != 6);
         sleepCmd(modes[k], 1'b1);
         chk("asleep", asleep_q, 1);
         chk("clk", clkEn_q, clkExp[k]);
         chk("mode", activeMode_q, modes[k]);
         chk("convStart", convSeen, k < 2);
         chk("periphSleep", periphClkEn_q, (k == 0) ? 8'hFF : 8'h00);
         spurSrc.extEdgeIrq = 1'b1;
         spurSrc.otherIoIrq = 1'b1;
         step(14);
         chk("strayWake", asleep_q, k != 0);
         spurSrc = '0;
         if (k != 0)
         begin
            irqReq = 1'b1;
            step(1);
            irqReq = 1'b0;
            cnt = 1;
            while (irqAck_q !== 1'b1 && cnt < 100)
            begin
               step(1);
               cnt++;
            end
            chk("wakeTime", cnt >= dly[k] + 4 && cnt <= dly[k] + 9, 1);
            step(2);
         end
         chk("halt", coreHalt_q, 0);
         chk("clkAwake", clkEn_q, 6'h3F);
      end
      // Reset while asleep goes to the reset vector
      {rvSeen, ackSeen} = '0;
      sleepCmd(smc_pkg::MODE_PDOWN, 1'b1);
      wakeReset = 1'b1;
      step(1);
      wakeReset = 1'b0;
      step(4);
      chk("resetVector", rvSeen, 1);
      chk("noHandler", ackSeen, 0);
      chk("awakeRst", asleep_q, 0);
      end_sim();
   end
endmodule
`default_nettype wire
